// [shared/sfbp_pkg.sv]
package sfbp_pkg;
    // ------------------------------------------------
    // Opcodes
    // ------------------------------------------------
    localparam logic [7:0] OP_PGM_B1  = 8'h88;
    localparam logic [7:0] OP_PGM_B2  = 8'h89;
    localparam logic [7:0] OP_LDE_B1  = 8'h82;
    localparam logic [7:0] OP_LDE_B2  = 8'h85;
    localparam logic [7:0] OP_BYTE_B1 = 8'h02;

    // ------------------------------------------------
    // Address layout and sizes
    // ------------------------------------------------
    localparam int         PAGE_W     = 15;
    localparam int         BYTE_W     = 9;
    localparam int         ARR_W      = 24;
    localparam int         BUF_AW     = 10;
    localparam int         TMR_W      = 24;
    localparam int         STD_PG_LSB = 9;
    localparam int         BIN_PG_LSB = 8;
    localparam logic [1:0] ADDR_LAST  = 2'h2;
    localparam logic [2:0] BIT_LAST   = 3'h7;
    localparam logic [8:0] STD_LAST   = 9'h107;
    localparam logic [8:0] BIN_LAST   = 9'h0ff;
    localparam logic [9:0] STD_SIZE   = 10'h108;
    localparam logic [9:0] BIN_SIZE   = 10'h100;

    // ------------------------------------------------
    // Timing
    // ------------------------------------------------
    localparam int               CORE_PERIOD_NS = 50;
    localparam logic [TMR_W-1:0] SETTLE_CYC     = 24'h000004;

    // ------------------------------------------------
    // State
    // ------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_SKIP, ST_ADDR, ST_DATA, ST_SETTLE,
        ST_ERASE, ST_P_RD, ST_P_LAT, ST_P_WAIT
    } sfbp_st_e;

    typedef struct packed {
        sfbp_st_e           st;
        logic [2:0]         cs_s;
        logic               cs_lvl;
        logic [2:0]         tg_s;
        logic               tg_lvl;
        logic [2:0]         od_s;
        logic               od_lvl;
        logic [7:0]         opc;
        logic [1:0]         aidx;
        logic [ARR_W-1:0]   addr;
        logic [PAGE_W-1:0]  page;
        logic [BYTE_W-1:0]  start;
        logic [BYTE_W-1:0]  bptr;
        logic [9:0]         nbytes;
        logic [9:0]         pcnt;
        logic [TMR_W-1:0]   tmr;
        logic               mem_we;
        logic [BUF_AW-1:0]  mem_wa;
        logic [7:0]         mem_wd;
        logic               busy;
        logic               err;
        logic [ARR_W-1:0]   arr_addr;
        logic [7:0]         arr_wdata;
        logic               arr_prog;
        logic               arr_erase;
    } sfbp_core_s;

    typedef struct packed {
        logic [7:0] sh;
        logic [7:0] rx;
        logic       tgl;
        logic       odd;
    } sfbp_lnk_s;
endpackage : sfbp_pkg

// [design/sfbp_buf_mem.sv]
`timescale 1ns/1ps
module sfbp_buf_mem #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule : sfbp_buf_mem

// [design/sfbp_top.sv]
// Function
// (RULE1) 88h/89h program buffer 1/2, no erase
// (RULE2) Standard: 15 page bits, 9 ignored
// (RULE3) Binary: 1 ignored, 15 page, 8 ignored
// (RULE4) CS rise copies buffer, busy meanwhile
// (RULE5) Host pre-erases page before no-erase program
// (RULE6) Verify bytes, flag error on mismatch
// (RULE7) 82h/85h load buffer, erase, program
// (RULE8) Standard: 15 page bits, 9 buffer bits
// (RULE9) Binary: 1 ignored, 15 page, 8 buffer
// (RULE10) Data fills buffer, wrapping at end
// (RULE11) CS rise erases page then programs
// (RULE12) 02h program through buffer 1, no erase
// (RULE13) 02h takes one to page-size bytes
// (RULE14) 02h programs only received bytes
// (RULE15) CS off byte boundary aborts 02h
// (RULE16) 02h time scales with byte count
// (RULE17) Binary: 23-bit linear byte address
// (RULE18) MSB first, address follows opcode directly
`timescale 1ns/1ps
module sfbp_top
    import sfbp_pkg::*;
#(
    parameter int unsigned PER_BYTE_PROGRAM_TIME_NS = 8000,
    parameter int unsigned ERASE_PHASE_TIME_NS      = 1000000
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst_b,
    input  wire logic                      spi_clk,
    input  wire logic                      cs_b,
    input  wire logic                      si,
    input  wire logic                      page_size_binary,
    input  wire logic [7:0]                array_rdata,
    output logic                           busy,
    output logic                           program_erase_error_flag,
    output logic      [sfbp_pkg::ARR_W-1:0] array_addr,
    output logic      [7:0]                array_wdata,
    output logic                           array_prog,
    output logic                           array_erase
);
    import sfbp_pkg::*;

    localparam int BP_RAW = PER_BYTE_PROGRAM_TIME_NS / CORE_PERIOD_NS;
    localparam int ER_RAW = ERASE_PHASE_TIME_NS / CORE_PERIOD_NS;
    localparam logic [TMR_W-1:0] BP_CYC = TMR_W'((BP_RAW < 1) ? 1 : BP_RAW);
    localparam logic [TMR_W-1:0] ER_CYC = TMR_W'((ER_RAW < 1) ? 1 : ER_RAW);

    // ------------------------------------------------
    // Decode helpers
    // ------------------------------------------------
    function automatic logic known_op(input logic [7:0] o);
        return o == OP_PGM_B1 || o == OP_PGM_B2 || o == OP_LDE_B1 ||
               o == OP_LDE_B2 || o == OP_BYTE_B1;
    endfunction : known_op

    function automatic logic is_lde(input logic [7:0] o);
        return o == OP_LDE_B1 || o == OP_LDE_B2;
    endfunction : is_lde

    function automatic logic buf_of(input logic [7:0] o);
        return o == OP_PGM_B2 || o == OP_LDE_B2;
    endfunction : buf_of

    function automatic logic [9:0] size_f(input logic bin);
        return bin ? BIN_SIZE : STD_SIZE;
    endfunction : size_f

    function automatic logic [8:0] wrap_inc(input logic bin, input logic [8:0] p);
        logic [8:0] last;
        last = bin ? BIN_LAST : STD_LAST;
        return (p == last) ? 9'h000 : p + 9'h001;
    endfunction : wrap_inc

    function automatic logic [PAGE_W-1:0] page_f(input logic bin, input logic [ARR_W-1:0] a);
        return bin ? a[BIN_PG_LSB +: PAGE_W] : a[STD_PG_LSB +: PAGE_W];
    endfunction : page_f

    function automatic logic [BYTE_W-1:0] start_f(input logic bin, input logic [ARR_W-1:0] a);
        return bin ? {1'b0, a[BIN_PG_LSB-1:0]} : a[BYTE_W-1:0];
    endfunction : start_f

    function automatic logic [ARR_W-1:0] arr_f(input logic bin, input logic [PAGE_W-1:0] pg,
                                               input logic [BYTE_W-1:0] b);
        return bin ? {1'b0, pg, b[BIN_PG_LSB-1:0]} : {pg, b};
    endfunction : arr_f

    // ------------------------------------------------
    // Link domain: shifts bytes in on the serial clock
    // ------------------------------------------------
    sfbp_lnk_s  l_q;
    sfbp_lnk_s  l_d;
    logic [2:0] bcnt_q;
    logic       lnk_clr;

    assign lnk_clr = cs_b | !rst_b;

    always_ff @(posedge spi_clk or posedge lnk_clr) begin
        if (lnk_clr) begin
            bcnt_q <= '0;
        end else begin
            bcnt_q <= bcnt_q + 3'h1;
        end
    end

    always_comb begin
        l_d     = l_q;
        l_d.sh  = {l_q.sh[6:0], si};               // [RULE18]
        l_d.odd = (bcnt_q != BIT_LAST);
        if (bcnt_q == BIT_LAST) begin
            l_d.rx  = {l_q.sh[6:0], si};
            l_d.tgl = !l_q.tgl;
        end
    end

    always_ff @(posedge spi_clk or negedge rst_b) begin
        if (!rst_b) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // ------------------------------------------------
    // Core domain
    // ------------------------------------------------
    sfbp_core_s  q;
    sfbp_core_s  n;
    logic        cs_rise;
    logic        tg_ev;
    logic        bin;
    logic        byte_op;
    logic        loading;
    logic [7:0]  mem_rdata;
    logic [ARR_W-1:0] addr_nx;
    sfbp_st_e    st_after;

    assign bin      = page_size_binary;
    assign cs_rise  = (q.cs_s[1] == q.cs_s[2]) && q.cs_s[2] && !q.cs_lvl;
    assign tg_ev    = (q.tg_s[1] == q.tg_s[2]) && (q.tg_s[2] != q.tg_lvl);
    assign byte_op  = (q.opc == OP_BYTE_B1);
    assign loading  = is_lde(q.opc) || byte_op;
    assign addr_nx  = {q.addr[15:0], l_q.rx};                 // [RULE18]
    assign st_after = q.cs_lvl ? ST_IDLE : ST_SKIP;

    sfbp_buf_mem #(
        .AW(BUF_AW),
        .DW(8)
    ) u_mem (
        .clk  (core_clk),
        .rst_b(rst_b),
        .we   (q.mem_we),
        .waddr(q.mem_wa),
        .wdata(q.mem_wd),
        .raddr({buf_of(q.opc), q.bptr}),
        .rdata(mem_rdata)
    );

    always_comb begin
        n           = q;
        n.mem_we    = 1'b0;
        n.arr_prog  = 1'b0;
        n.arr_erase = 1'b0;
        n.cs_s      = {q.cs_s[1:0], cs_b};
        n.tg_s      = {q.tg_s[1:0], l_q.tgl};
        n.od_s      = {q.od_s[1:0], l_q.odd};
        if (q.cs_s[1] == q.cs_s[2]) begin
            n.cs_lvl = q.cs_s[2];
        end
        if (q.tg_s[1] == q.tg_s[2]) begin
            n.tg_lvl = q.tg_s[2];
        end
        if (q.od_s[1] == q.od_s[2]) begin
            n.od_lvl = q.od_s[2];
        end
        // Data bytes land in the buffer, also a late one after CS rise
        if (tg_ev && loading && (q.st == ST_DATA || q.st == ST_SETTLE)) begin
            n.mem_we = 1'b1;
            n.mem_wa = {buf_of(q.opc), q.bptr};              // [RULE10]
            n.mem_wd = l_q.rx;
            n.bptr   = wrap_inc(bin, q.bptr);                // [RULE10]
            if (q.nbytes != size_f(bin)) begin
                n.nbytes = q.nbytes + 10'h001;               // [RULE13]
            end
        end
        case (q.st)
            ST_IDLE: begin
                if (tg_ev) begin
                    n.opc  = l_q.rx;
                    n.aidx = '0;
                    n.st   = known_op(l_q.rx) ? ST_ADDR : ST_SKIP; // [RULE1] [RULE7] [RULE12]
                end
            end
            ST_SKIP: begin
                if (cs_rise) begin
                    n.st = ST_IDLE;
                end
            end
            ST_ADDR: begin
                if (cs_rise) begin
                    n.st = ST_IDLE;
                end else if (tg_ev) begin
                    n.addr = addr_nx;
                    n.aidx = q.aidx + 2'h1;
                    if (q.aidx == ADDR_LAST) begin
                        n.page   = page_f(bin, addr_nx);     // [RULE2] [RULE3] [RULE8] [RULE9]
                        n.start  = start_f(bin, addr_nx);    // [RULE8] [RULE9]
                        n.bptr   = start_f(bin, addr_nx);
                        n.nbytes = '0;
                        n.st     = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (cs_rise) begin
                    n.tmr = SETTLE_CYC;
                    n.st  = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (q.tmr != '0) begin
                    n.tmr = q.tmr - 24'h000001;
                end else if (byte_op && (q.od_lvl || q.nbytes == '0)) begin
                    n.st = st_after;                          // [RULE15]
                end else begin
                    n.busy     = 1'b1;                        // [RULE4] [RULE11]
                    n.err      = 1'b0;
                    n.bptr     = byte_op ? q.start : '0;      // [RULE14]
                    n.pcnt     = byte_op ? q.nbytes : size_f(bin); // [RULE14] [RULE16]
                    n.arr_addr = arr_f(bin, q.page, '0);
                    if (is_lde(q.opc)) begin
                        n.arr_erase = 1'b1;                   // [RULE11]
                        n.tmr       = ER_CYC;
                        n.st        = ST_ERASE;
                    end else begin
                        n.st = ST_P_RD;                       // [RULE1]
                    end
                end
            end
            ST_ERASE: begin
                if (q.tmr > 24'h000001) begin
                    n.tmr = q.tmr - 24'h000001;
                end else begin
                    n.st = ST_P_RD;                           // [RULE11]
                end
            end
            ST_P_RD: begin
                n.st = ST_P_LAT;
            end
            ST_P_LAT: begin
                n.arr_wdata = mem_rdata;
                n.arr_addr  = arr_f(bin, q.page, q.bptr);     // [RULE17]
                n.arr_prog  = 1'b1;
                n.tmr       = BP_CYC;                         // [RULE16]
                n.st        = ST_P_WAIT;
            end
            ST_P_WAIT: begin
                if (q.tmr > 24'h000001) begin
                    n.tmr = q.tmr - 24'h000001;
                end else begin
                    if (array_rdata != q.arr_wdata) begin
                        n.err = 1'b1;                         // [RULE6]
                    end
                    n.bptr = wrap_inc(bin, q.bptr);
                    n.pcnt = q.pcnt - 10'h001;
                    if (q.pcnt == 10'h001) begin
                        n.busy = 1'b0;                        // [RULE4]
                        n.st   = st_after;
                    end else begin
                        n.st = ST_P_RD;
                    end
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign busy                     = q.busy;
    assign program_erase_error_flag = q.err;
    assign array_addr               = q.arr_addr;
    assign array_wdata              = q.arr_wdata;
    assign array_prog               = q.arr_prog;
    assign array_erase              = q.arr_erase;

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    logic [9:0]       pc_q;
    logic [ARR_W-1:0] addr_nx_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_q      <= '0;
            addr_nx_q <= '0;
        end else begin
            addr_nx_q <= addr_nx;
            if (q.st == ST_SETTLE) begin
                pc_q <= '0;
            end else if (q.arr_prog) begin
                pc_q <= pc_q + 10'h001;
            end
        end
    end

    sequence s_addr_done;
        q.st == ST_ADDR && tg_ev && q.aidx == ADDR_LAST;
    endsequence

    sequence s_settle_end;
        q.st == ST_SETTLE && q.tmr == '0;
    endsequence

    property p_busy_on_cs;
        @(posedge core_clk) disable iff (!rst_b)
        q.st == ST_DATA && cs_rise && !byte_op |-> ##[1:8] q.busy;
    endproperty
    a_busy_on_cs: assert property (p_busy_on_cs) else $error("busy not raised"); // [RULE4]

    property p_no_erase;
        @(posedge core_clk) disable iff (!rst_b)
        q.busy && (q.opc == OP_PGM_B1 || q.opc == OP_PGM_B2 || byte_op) |-> !q.arr_erase;
    endproperty
    a_no_erase: assert property (p_no_erase) else $error("erase on no-erase op"); // [RULE1]

    property p_erase_first;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(q.busy) && is_lde(q.opc) |-> q.arr_erase ##1 (!q.arr_prog)[*2];
    endproperty
    a_erase_first: assert property (p_erase_first) else $error("erase not first"); // [RULE11]

    property p_abort;
        @(posedge core_clk) disable iff (!rst_b)
        s_settle_end and (byte_op && q.od_lvl) |=> (!q.busy && !q.arr_prog)[*4];
    endproperty
    a_abort: assert property (p_abort) else $error("partial byte not aborted"); // [RULE15]

    property p_count;
        @(posedge core_clk) disable iff (!rst_b)
        $fell(q.busy) && byte_op |-> pc_q == q.nbytes;
    endproperty
    a_count: assert property (p_count) else $error("wrong byte count"); // [RULE14]

    property p_verify;
        @(posedge core_clk) disable iff (!rst_b)
        q.st == ST_P_WAIT && q.tmr <= 24'h000001 && array_rdata != q.arr_wdata |=> q.err;
    endproperty
    a_verify: assert property (p_verify) else $error("error flag missed"); // [RULE6]

    property p_wrap;
        @(posedge core_clk) disable iff (!rst_b)
        q.st == ST_DATA && tg_ev && loading |=> q.mem_we && q.mem_wa[8:0] == $past(q.bptr)
            && q.bptr == wrap_inc(bin, $past(q.bptr));
    endproperty
    a_wrap: assert property (p_wrap) else $error("buffer pointer wrong"); // [RULE10]

    property p_byte_time;
        @(posedge core_clk) disable iff (!rst_b)
        q.arr_prog |-> q.tmr == BP_CYC ##1 !q.arr_prog;
    endproperty
    a_byte_time: assert property (p_byte_time) else $error("per-byte time wrong"); // [RULE16]

    property p_linear;
        @(posedge core_clk) disable iff (!rst_b)
        q.arr_prog && bin |-> q.arr_addr == {1'b0, q.page, q.bptr[7:0]};
    endproperty
    a_linear: assert property (p_linear) else $error("linear address wrong"); // [RULE17]

    property p_page_std;
        @(posedge core_clk) disable iff (!rst_b)
        s_addr_done and !bin |=> q.page == addr_nx_q[23:9] && q.st == ST_DATA;
    endproperty
    a_page_std: assert property (p_page_std) else $error("standard page wrong"); // [RULE2] [RULE8]

    property p_page_bin;
        @(posedge core_clk) disable iff (!rst_b)
        s_addr_done and bin |=> q.page == addr_nx_q[22:8] && q.start == {1'b0, addr_nx_q[7:0]};
    endproperty
    a_page_bin: assert property (p_page_bin) else $error("binary page wrong"); // [RULE3] [RULE9]
endmodule : sfbp_top

// [verification/sfbp_host_model.sv]
`timescale 1ns/1ps
module sfbp_host_model (
    output logic spi_clk,
    output logic cs_b,
    output logic si
);
    logic [7:0] tx_q[$];

    initial begin
        spi_clk = 1'b0;
        cs_b    = 1'b1;
        si      = 1'b1;
    end

    // ------------------------------------------------
    // Serial frame, 160 ns clock, idle low outside frames
    // ------------------------------------------------
    task automatic bit_out(input logic v);
        si = v;
        #80 spi_clk = 1'b1;
        #80 spi_clk = 1'b0;
    endtask : bit_out

    task automatic frame(input int extra);
        logic [7:0] b;
        #37 cs_b = 1'b0;
        while (tx_q.size() > 0) begin
            b = tx_q.pop_front();
            for (int i = 7; i >= 0; i--) bit_out(b[i]);
        end
        repeat (extra) bit_out(1'b1);
        #80 cs_b = 1'b1;
        si = ~si;
        #2000;
    endtask : frame
endmodule : sfbp_host_model

// [verification/sfbp_top_tb.sv]
`timescale 1ns/1ps
module sfbp_top_tb;
    import sfbp_pkg::*;
    localparam int BP = 4;
    logic              core_clk = 1'b0;
    logic              rst_b;
    logic              page_size_binary;
    logic              fault;
    logic [7:0]        array_rdata;
    logic              spi_clk, cs_b, si, busy, err_flag, array_prog, array_erase;
    logic [ARR_W-1:0]  array_addr;
    logic [7:0]        array_wdata;
    logic [7:0]        mem [logic [23:0]];
    logic [7:0]        exp_mem [logic [23:0]];
    logic [7:0]        buf_q [2][264];
    logic [31:0]       seed = 32'h000129e4;
    int                miscompares, n_checks, n_prog, n_erase, busy_cyc, b1;

    always #25 core_clk = ~core_clk;

    sfbp_top #(
        .PER_BYTE_PROGRAM_TIME_NS (200),
        .ERASE_PHASE_TIME_NS      (500)
    ) u_sfbp_top (
        .core_clk                 (core_clk),
        .rst_b                    (rst_b),
        .spi_clk                  (spi_clk),
        .cs_b                     (cs_b),
        .si                       (si),
        .page_size_binary         (page_size_binary),
        .array_rdata              (array_rdata),
        .busy                     (busy),
        .program_erase_error_flag (err_flag),
        .array_addr               (array_addr),
        .array_wdata              (array_wdata),
        .array_prog               (array_prog),
        .array_erase              (array_erase)
    );

    sfbp_host_model u_sfbp_host_model (
        .spi_clk (spi_clk),
        .cs_b    (cs_b),
        .si      (si)
    );

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [7:0] rd(input logic [23:0] a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction : rd

    function automatic logic [7:0] ex(input logic [23:0] a);
        return exp_mem.exists(a) ? exp_mem[a] : 8'hff;
    endfunction : ex

    function automatic logic [23:0] loc(input logic [14:0] pg, input logic [8:0] by);
        return page_size_binary ? {1'b0, pg, by[7:0]} : {pg, by};
    endfunction : loc

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    // ------------------------------------------------
    // Flash array: erase to ones, program clears bits
    // ------------------------------------------------
    always @(negedge core_clk) begin
        if (array_erase) begin
            n_erase++;
            for (int i = 0; i < (page_size_binary ? 256 : 264); i++) begin
                if (page_size_binary) mem[{array_addr[23:8], 8'h00} + 24'(i)] = 8'hff;
                else mem[{array_addr[23:9], 9'h000} + 24'(i)] = 8'hff;
            end
        end
        if (array_prog) begin
            n_prog++;
            mem[array_addr] = rd(array_addr) & array_wdata;
        end
        busy_cyc += int'(busy);
        array_rdata <= rd(array_addr) ^ {7'h00, fault};
    end

    task automatic run_op(input logic [7:0] opc, input int n, input logic [8:0] st, input int extra,
                          input logic want_err);
        int          size, bsel, np, ne, k;
        logic [14:0] pg;
        logic [8:0]  p;
        logic [7:0]  d;
        logic [23:0] a;
        size = page_size_binary ? 256 : 264;
        bsel = (opc == OP_PGM_B2 || opc == OP_LDE_B2) ? 1 : 0;
        pg = 15'(rnd());
        a = loc(pg, st);
        if (page_size_binary) a[23] = ~pg[0];
        u_sfbp_host_model.tx_q = {opc, a[23:16], a[15:8], a[7:0]};
        p = st;
        for (int i = 0; i < n; i++) begin
            d = 8'(rnd());
            u_sfbp_host_model.tx_q.push_back(d);
            buf_q[bsel][p] = d;
            p = (p == 9'(size - 1)) ? 9'h000 : p + 9'h001;
        end
        n_prog = 0;
        n_erase = 0;
        busy_cyc = 0;
        u_sfbp_host_model.frame(extra);
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (busy !== 1'b0 && k < 4000);
        if (k >= 4000) begin
            miscompares++;
            complete_run();
        end
        ne = (opc == OP_LDE_B1 || opc == OP_LDE_B2) ? 1 : 0;
        np = (opc != OP_BYTE_B1) ? size : (extra != 0) ? 0 : n;
        p = (opc == OP_BYTE_B1) ? st : 9'h000;
        for (int i = 0; i < size; i++) if (ne != 0) exp_mem[loc(pg, 9'(i))] = 8'hff;
        for (int i = 0; i < np; i++) begin
            a = loc(pg, p);
            exp_mem[a] = ex(a) & buf_q[bsel][p];
            p = (p == 9'(size - 1)) ? 9'h000 : p + 9'h001;
        end
        check(n_erase, ne);
        check(n_prog, np);
        check(busy_cyc > 0, np > 0);
        check(err_flag, want_err);
        for (int i = 0; i < size; i++) check(rd(loc(pg, 9'(i))), ex(loc(pg, 9'(i))));
    endtask : run_op

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        rst_b = 1'b0;
        page_size_binary = 1'b0;
        fault = 1'b0;
        array_rdata = 8'hff;
        miscompares = 0;
        n_checks = 0;
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (6) @(negedge core_clk);
        check(busy, 1'b0);
        for (int m = 0; m < 2; m++) begin
            page_size_binary = m[0];
            run_op(OP_LDE_B1, m ? 256 : 264, 9'(rnd() % (m ? 256 : 264)), 0, 1'b0);
            run_op(OP_LDE_B2, m ? 256 : 264, 9'(rnd() % (m ? 256 : 264)), 0, 1'b0);
            run_op(OP_PGM_B1, 0, 9'(rnd()), 0, 1'b0);
            run_op(OP_PGM_B2, 0, 9'(rnd()), 0, 1'b0);
        end
        page_size_binary = 1'b0;
        run_op(OP_BYTE_B1, 2, 9'h107, 0, 1'b0);
        run_op(OP_BYTE_B1, 1, 9'(rnd() % 264), 0, 1'b0);
        b1 = busy_cyc;
        run_op(OP_BYTE_B1, 3, 9'(rnd() % 264), 0, 1'b0);
        check(busy_cyc - b1, 2 * (BP + 2));
        run_op(OP_BYTE_B1, 2, 9'h010, 3, 1'b0);
        page_size_binary = 1'b1;
        run_op(OP_BYTE_B1, 2, 9'h0ff, 0, 1'b0);
        fault = 1'b1;
        run_op(OP_PGM_B1, 0, 9'h000, 0, 1'b1);
        fault = 1'b0;
        run_op(OP_BYTE_B1, 1, 9'h020, 0, 1'b0);
        // Unknown opcode, then a frame cut inside the address: nothing may start
        for (int f = 0; f < 2; f++) begin
            if (f == 0) u_sfbp_host_model.tx_q = {8'h84, 8'h00, 8'h00, 8'h00, 8'ha5};
            else u_sfbp_host_model.tx_q = {OP_PGM_B1, 8'h12};
            n_prog = 0;
            n_erase = 0;
            busy_cyc = 0;
            u_sfbp_host_model.frame(0);
            check(n_prog + n_erase + busy_cyc, 0);
            check(busy, 1'b0);
        end
        complete_run();
    end
endmodule : sfbp_top_tb
